// *** design/port_edge_change_detector.sv ***
// Port edge-change detector with its AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "port_edge_regs.svh"

module port_edge_change_detector
   import port_edge_pkg::*;
#(
   parameter int NUM_PINS = 6        // Port pins watched
)(
   input wire logic clk,                          // System clock, 100 MHz
   input wire logic resetn,                       // Asynchronous reset, active low
   input wire logic [NUM_PINS-1:0] port_a_pin,    // Port pin levels
   input wire logic [11:0] s_axi_awaddr,          // Write address
   input wire logic s_axi_awvalid,                // Write address valid
   output logic s_axi_awready,                    // Write address ready
   input wire logic [31:0] s_axi_wdata,           // Write data
   input wire logic [3:0] s_axi_wstrb,            // Write byte strobes
   input wire logic s_axi_wvalid,                 // Write data valid
   output logic s_axi_wready,                     // Write data ready
   output logic [1:0] s_axi_bresp,                // Write response
   output logic s_axi_bvalid,                     // Write response valid
   input wire logic s_axi_bready,                 // Write response ready
   input wire logic [11:0] s_axi_araddr,          // Read address
   input wire logic s_axi_arvalid,                // Read address valid
   output logic s_axi_arready,                    // Read address ready
   output logic [31:0] s_axi_rdata,               // Read data
   output logic [1:0] s_axi_rresp,                // Read response
   output logic s_axi_rvalid,                     // Read data valid
   input wire logic s_axi_rready,                 // Read data ready
   output logic [NUM_PINS-1:0] pin_change_flag,   // Per-pin change flags
   output logic irq                               // Interrupt request, active high
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (NUM_PINS < 1 || NUM_PINS > 6) begin : g_bad_pins
      $error("NUM_PINS must be 1 to 6");
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   localparam logic [9:0] CTL_INDEX = `IDX_INTERRUPT_CONTROL;

   function automatic reg_sel_t decode(input logic [11:0] addr);
      logic [9:0] idx;
      idx = addr[11:2];
      // Only the in-bank part is compared, so every bank reaches it
      if (idx[`IDX_IN_BANK_BITS-1:0] == CTL_INDEX[`IDX_IN_BANK_BITS-1:0]) begin
         decode = SEL_CTL;
      end else if (idx == `IDX_RISE_EDGE_ENABLE) begin
         decode = SEL_RISE;
      end else if (idx == `IDX_FALL_EDGE_ENABLE) begin
         decode = SEL_FALL;
      end else if (idx == `IDX_PIN_CHANGE_FLAG) begin
         decode = SEL_FLAG;
      end else begin
         decode = SEL_NONE;
      end
   endfunction : decode

   // ****************************************************************
   // Register state
   // ****************************************************************
   interrupt_control_t interrupt_control;
   logic [NUM_PINS-1:0] rise_edge_enable;
   logic [NUM_PINS-1:0] fall_edge_enable;
   interrupt_control_t next_interrupt_control;
   logic [NUM_PINS-1:0] next_rise_edge_enable;
   logic [NUM_PINS-1:0] next_fall_edge_enable;
   logic [NUM_PINS-1:0] next_pin_change_flag;
   logic next_irq;
   logic [NUM_PINS-1:0] pin_event;

   // ****************************************************************
   // Pin lanes
   // ****************************************************************
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_lane
      edge_detect_lane u_lane (
         .clk(clk),
         .resetn(resetn),
         .pin(port_a_pin[i]),
         .cfg({rise_edge_enable[i], fall_edge_enable[i]}),
         .change_event(pin_event[i])
      );
   end

   // ****************************************************************
   // Write channel
   // ****************************************************************
   wr_state_t wr_state;
   wr_state_t next_wr_state;
   logic aw_full;
   logic w_full;
   logic [11:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   logic next_aw_full;
   logic next_w_full;
   logic [11:0] next_aw_addr;
   logic [7:0] next_w_byte;
   logic next_w_lane0;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic do_write;
   reg_sel_t wr_sel;

   always_comb begin
      next_wr_state = wr_state;
      next_aw_full = aw_full;
      next_w_full = w_full;
      next_aw_addr = aw_addr;
      next_w_byte = w_byte;
      next_w_lane0 = w_lane0;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      wr_sel = decode(aw_addr);
      do_write = 1'b0;
      case (wr_state)
         WR_COLLECT: begin
            if (s_axi_awvalid && s_axi_awready) begin
               next_aw_full = 1'b1;
               next_aw_addr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               next_w_full = 1'b1;
               next_w_byte = s_axi_wdata[7:0];
               next_w_lane0 = s_axi_wstrb[0];
            end
            if (aw_full && w_full) begin
               do_write = 1'b1;
               next_bvalid = 1'b1;
               next_bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
               next_wr_state = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready) begin
               next_bvalid = 1'b0;
               next_aw_full = 1'b0;
               next_w_full = 1'b0;
               next_wr_state = WR_COLLECT;
            end
         end
         default: begin
            next_wr_state = WR_COLLECT;
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b0;
         end
      endcase
      next_awready = (next_wr_state == WR_COLLECT) && !next_aw_full;
      next_wready = (next_wr_state == WR_COLLECT) && !next_w_full;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_state <= WR_COLLECT;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 12'h000;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         wr_state <= next_wr_state;
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         aw_addr <= next_aw_addr;
         w_byte <= next_w_byte;
         w_lane0 <= next_w_lane0;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
      end
   end

   // ****************************************************************
   // Register update
   // ****************************************************************
   // Byte lane 0 alone carries register data; other lanes are ignored
   always_comb begin
      logic wr_byte;
      wr_byte = do_write && w_lane0;
      next_interrupt_control = interrupt_control;
      next_rise_edge_enable = rise_edge_enable;
      next_fall_edge_enable = fall_edge_enable;
      next_pin_change_flag = pin_change_flag;
      if (wr_byte && wr_sel == SEL_CTL) begin
         next_interrupt_control = interrupt_control_t'(w_byte);
      end
      if (wr_byte && wr_sel == SEL_RISE) begin
         next_rise_edge_enable = w_byte[NUM_PINS-1:0];
      end
      if (wr_byte && wr_sel == SEL_FALL) begin
         next_fall_edge_enable = w_byte[NUM_PINS-1:0];
      end
      if (wr_byte && wr_sel == SEL_FLAG) begin
         next_pin_change_flag = w_byte[NUM_PINS-1:0];
      end
      // Set beats a clear written in the same cycle
      next_pin_change_flag = next_pin_change_flag | pin_event;
      if (|pin_event) begin
         next_interrupt_control.change_summary_flag = 1'b1;
      end
      next_irq = interrupt_control.change_summary_flag &
                 interrupt_control.change_irq_enable &
                 interrupt_control.global_irq_enable;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_control <= interrupt_control_t'(`RST_INTERRUPT_CONTROL);
         rise_edge_enable <= NUM_PINS'(`RST_EDGE_ENABLE);
         fall_edge_enable <= NUM_PINS'(`RST_EDGE_ENABLE);
         pin_change_flag <= NUM_PINS'(`RST_PIN_CHANGE_FLAG);
         irq <= 1'b0;
      end else begin
         interrupt_control <= next_interrupt_control;
         rise_edge_enable <= next_rise_edge_enable;
         fall_edge_enable <= next_fall_edge_enable;
         pin_change_flag <= next_pin_change_flag;
         irq <= next_irq;
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   rd_state_t rd_state;
   rd_state_t next_rd_state;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   always_comb begin
      reg_sel_t rd_sel;
      logic [7:0] rd_byte;
      rd_sel = decode(s_axi_araddr);
      rd_byte = 8'h00;
      next_rd_state = rd_state;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      case (rd_sel)
         SEL_CTL: rd_byte = interrupt_control;
         SEL_RISE: rd_byte[NUM_PINS-1:0] = rise_edge_enable;
         SEL_FALL: rd_byte[NUM_PINS-1:0] = fall_edge_enable;
         SEL_FLAG: rd_byte[NUM_PINS-1:0] = pin_change_flag;
         default: rd_byte = 8'h00;
      endcase
      case (rd_state)
         RD_IDLE: begin
            if (s_axi_arvalid && s_axi_arready) begin
               next_rvalid = 1'b1;
               next_rdata = {24'h000000, rd_byte};
               next_rresp = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
               next_rd_state = RD_DATA;
            end
         end
         RD_DATA: begin
            if (s_axi_rready) begin
               next_rvalid = 1'b0;
               next_rd_state = RD_IDLE;
            end
         end
         default: begin
            next_rvalid = 1'b0;
            next_rd_state = RD_IDLE;
         end
      endcase
      next_arready = (next_rd_state == RD_IDLE);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_state <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         rd_state <= next_rd_state;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

endmodule : port_edge_change_detector

`default_nettype wire

// *** design/port_edge_regs.svh ***
// Register indices, field positions and reset values of the port edge-change detector
// Summary of operation
// - Every pin has its own rising-edge enable bit; when set, a low-to-high change is an event.
// - Every pin has its own falling-edge enable bit; when set, a high-to-low change is an event.
// - A rising change on a pin whose rising enable is set sets that pin's change flag.
// - A falling change on a pin whose falling enable is set sets that pin's change flag.
// - Any enabled edge also sets the shared summary flag in the interrupt control register.
// - A pin with both edge enables clear never sets any flag.
// - Hardware sets the pin flags, software reads and writes them and clears one by writing zero.
// - The two top bits of the enable and flag registers are unimplemented and read zero.
// - Enables and flags are zero after every kind of reset.
// - The interrupt control register answers at the same in-bank index from every bank.
`ifndef PORT_EDGE_REGS_SVH
`define PORT_EDGE_REGS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_INTERRUPT_CONTROL 10'h00B
`define IDX_RISE_EDGE_ENABLE 10'h010
`define IDX_FALL_EDGE_ENABLE 10'h011
`define IDX_PIN_CHANGE_FLAG 10'h012
`define IDX_IN_BANK_BITS 7

// ****************************************************************
// Interrupt control fields
// ****************************************************************
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define BIT_CHANGE_IRQ_ENABLE 3
`define BIT_CHANGE_SUMMARY_FLAG 0

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_EDGE_ENABLE 8'h00
`define RST_PIN_CHANGE_FLAG 8'h00

`endif

// *** design/port_edge_pkg.sv ***
// Types shared by the port edge-change detector
package port_edge_pkg;

   typedef struct packed {
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic timer_irq_enable;
      logic ext_irq_enable;
      logic change_irq_enable;
      logic timer_flag;
      logic ext_flag;
      logic change_summary_flag;
   } interrupt_control_t;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'b00,
      RESP_SLVERR = 2'b10
   } axi_resp_t;

   typedef enum logic [4:0] {
      SEL_NONE = 5'b00001,
      SEL_CTL = 5'b00010,
      SEL_RISE = 5'b00100,
      SEL_FALL = 5'b01000,
      SEL_FLAG = 5'b10000
   } reg_sel_t;

   typedef enum logic [1:0] {
      WR_COLLECT = 2'b01,
      WR_RESP = 2'b10
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } rd_state_t;

   typedef struct packed {
      logic rise_enable;
      logic fall_enable;
   } edge_cfg_t;

endpackage : port_edge_pkg

// *** design/edge_detect_lane.sv ***
// One pin's sampler and edge qualifier
`timescale 1ns/1ps
`default_nettype none

module edge_detect_lane
   import port_edge_pkg::*;
(
   input wire logic clk,             // System clock
   input wire logic resetn,          // Asynchronous reset, active low
   input wire logic pin,             // Port pin level, clock synchronous
   input wire edge_cfg_t cfg,        // Edge enables for this pin
   output logic change_event         // Enabled edge seen this cycle
);

   logic last_sample;
   logic primed;
   logic next_last_sample;
   logic next_primed;

   always_comb begin
      next_last_sample = pin;
      next_primed = 1'b1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_sample <= 1'b0;
         primed <= 1'b0;
      end else begin
         last_sample <= next_last_sample;
         primed <= next_primed;
      end
   end

   // No compare until a real sample exists, else a high pin fakes a rise
   always_comb begin
      change_event = primed &
         ((cfg.rise_enable & pin & ~last_sample) |
          (cfg.fall_enable & ~pin & last_sample));
   end

endmodule : edge_detect_lane

`default_nettype wire

// *** tb/port_pin_driver.sv ***
// Model of the circuit that drives the six port pins
`timescale 1ns/1ps
`default_nettype none

module port_pin_driver (
   input wire logic clk,            // System clock
   input wire logic resetn,         // Asynchronous reset, active low
   input wire logic [5:0] level,    // Levels asked for by the bench
   output logic [5:0] port_a_pin    // Pin levels seen by the detector
);
   // Pins move just after a clock edge and hold a full cycle at least
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         port_a_pin <= 6'h00;
      end else begin
         port_a_pin <= level;
      end
   end
endmodule : port_pin_driver

`default_nettype wire

// *** tb/port_edge_asserts.sv ***
// Port-level assertions for the port edge-change detector
`timescale 1ns/1ps
`default_nettype none

module port_edge_asserts
   import port_edge_pkg::*;
#(
   parameter int NUM_PINS = 6       // Port pins watched
)(
   input wire logic clk,                          // System clock
   input wire logic resetn,                       // Reset, active low
   input wire logic [NUM_PINS-1:0] port_a_pin,    // Pin levels
   input wire logic s_axi_awvalid,                // Write address valid
   input wire logic s_axi_awready,                // Write address ready
   input wire logic s_axi_wvalid,                 // Write data valid
   input wire logic s_axi_wready,                 // Write data ready
   input wire logic s_axi_bvalid,                 // Write response valid
   input wire logic [11:0] s_axi_araddr,          // Read address
   input wire logic s_axi_arvalid,                // Read address valid
   input wire logic s_axi_arready,                // Read address ready
   input wire logic [31:0] s_axi_rdata,           // Read data
   input wire logic [1:0] s_axi_rresp,            // Read response
   input wire logic s_axi_rvalid,                 // Read data valid
   input wire logic [NUM_PINS-1:0] pin_change_flag, // Change flags
   input wire logic irq                           // Interrupt request
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // A flag may only rise on a changed pin or on a register write
   chk_flag_set_cause: assert property (
      ((pin_change_flag & ~$past(pin_change_flag)) & ~($past(port_a_pin) ^ $past(port_a_pin, 2)))
      != '0 |-> $rose(s_axi_bvalid)) else $error("flag rose without a pin edge");
   chk_flag_clear_cause: assert property (
      (~pin_change_flag & $past(pin_change_flag)) != '0 |-> $rose(s_axi_bvalid))
      else $error("flag fell without a write");
   chk_irq_rise_cause: assert property (
      $rose(irq) |-> $past(s_axi_bvalid) || ($past(port_a_pin, 2) != $past(port_a_pin, 3)))
      else $error("irq rose without a cause");
   chk_irq_fall_cause: assert property (
      $fell(irq) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
      else $error("irq fell without a write");
   chk_reset_clear: assert property (
      $rose(resetn) |-> pin_change_flag == '0 && !irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("state not clear after reset");
   chk_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_wready && !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response timing wrong");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response timing wrong");
   chk_rdata_width: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("read data too wide");
   chk_unmapped_read: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr[8:2] > 7'h12
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
endmodule : port_edge_asserts

bind port_edge_change_detector port_edge_asserts #(.NUM_PINS(NUM_PINS)) u_chk (
   .clk(clk), .resetn(resetn), .port_a_pin(port_a_pin), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .pin_change_flag(pin_change_flag), .irq(irq));

`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the port edge-change detector
`timescale 1ns/1ps
`default_nettype none
`include "port_edge_regs.svh"

module tb;
   localparam logic [11:0] A_CTL = {`IDX_INTERRUPT_CONTROL, 2'b00};
   localparam logic [11:0] A_RISE = {`IDX_RISE_EDGE_ENABLE, 2'b00};
   localparam logic [11:0] A_FALL = {`IDX_FALL_EDGE_ENABLE, 2'b00};
   localparam logic [11:0] A_FLAG = {`IDX_PIN_CHANGE_FLAG, 2'b00};
   localparam logic [1:0] OK = 2'h0;
   localparam logic [1:0] ERR = 2'h2;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [5:0] level = 6'h00;
   logic [5:0] pins;
   logic [11:0] awaddr = 12'h000;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [11:0] araddr = 12'h000;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [5:0] flag;
   int checks = 0;
   int miscompares = 0;
   logic [11:0] regs [4] = '{A_CTL, A_RISE, A_FALL, A_FLAG};

   always #5 clk = ~clk;

   port_pin_driver u_pins (.clk(clk), .resetn(resetn), .level(level), .port_a_pin(pins));

   port_edge_change_detector #(.NUM_PINS(6)) dut (
      .clk(clk), .resetn(resetn), .port_a_pin(pins), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_change_flag(flag), .irq(irq));

   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Starts one edge late so a lowered ready never meets a raised one
   task automatic bus_write(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) begin
         miscompares++;
         tally_and_finish();
      end
      check("write response", {30'h0, bresp}, {30'h0, er});
   endtask : bus_write

   task automatic bus_read(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 50) begin
         miscompares++;
         tally_and_finish();
      end
      check("read data", rdata, {24'h000000, d});
      check("read response", {30'h0, rresp}, {30'h0, er});
   endtask : bus_read

   task automatic pins_to(input logic [5:0] v);
      @(posedge clk);
      level <= v;
      repeat (5) @(posedge clk);
   endtask : pins_to

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      for (int j = 0; j < 4; j++) bus_read(regs[j], 8'h00, OK);
      for (int j = 1; j < 4; j++) begin
         bus_write(regs[j], 8'hFF, OK);
         bus_read(regs[j], 8'h3F, OK);
         bus_write(regs[j], 8'h00, OK);
         bus_read(regs[j], 8'h00, OK);
      end
      // Lane 0 strobe low: write is ignored but still answered
      wstrb <= 4'hE;
      bus_write(A_RISE, 8'h3F, OK);
      wstrb <= 4'hF;
      bus_read(A_RISE, 8'h00, OK);
      bus_write(A_CTL, 8'h00, OK);
      for (int i = 0; i < 6; i++) begin
         bus_write(A_RISE, 8'h01 << i, OK);
         pins_to(6'h01 << i);
         check("flag on rise", {26'h0, flag}, 32'h1 << i);
         bus_write(A_FLAG, 8'h00, OK);
         bus_write(A_RISE, 8'h00, OK);
         bus_write(A_FALL, 8'h01 << i, OK);
         pins_to(6'h00);
         check("flag on fall", {26'h0, flag}, 32'h1 << i);
         bus_write(A_FLAG, 8'h00, OK);
         bus_write(A_FALL, 8'h00, OK);
      end
      bus_read(A_CTL, 8'h01, OK);
      bus_write(A_CTL, 8'h00, OK);
      pins_to(6'h3F);
      pins_to(6'h00);
      bus_read(A_FLAG, 8'h00, OK);
      bus_read(A_CTL, 8'h00, OK);
      bus_write(A_CTL, 8'h88, OK);
      bus_write(A_RISE, 8'h3F, OK);
      pins_to(6'h3F);
      check("irq on edge", {31'h0, irq}, 32'h1);
      bus_read(A_CTL, 8'h89, OK);
      bus_write(A_CTL, 8'h08, OK);
      repeat (2) @(posedge clk);
      check("irq after clear", {31'h0, irq}, 32'h0);
      pins_to(6'h00);
      pins_to(6'h3F);
      check("irq without global", {31'h0, irq}, 32'h0);
      // Summary written as one so the pending change survives the write
      bus_write(12'h42C, 8'h89, OK);
      repeat (2) @(posedge clk);
      check("irq after alias write", {31'h0, irq}, 32'h1);
      bus_read(12'h22C, 8'h89, OK);
      check("flag port", {26'h0, flag}, 32'h3F);
      // Mid-run reset with flags, rise enables and summary all set
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      for (int j = 0; j < 4; j++) bus_read(regs[j], 8'h00, OK);
      check("irq after reset", {31'h0, irq}, 32'h0);
      bus_write(12'h0F0, 8'h55, ERR);
      bus_read(12'h0F0, 8'h00, ERR);
      bus_read(12'h240, 8'h00, ERR);
      tally_and_finish();
   end
endmodule : tb

`default_nettype wire
